/* File: hw/astc_top.sv */
// Purpose: converter sample rhythm, settling delay and gain switching control
// Assumes: classic Wishbone slave, single 100 MHz clock
// Notes:   software rescales period and settling counts for other clock rates

module astc_top
  import astc_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // wishbone slave
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [7:0]                  adr_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  // converter
  input  wire logic                        conv_done_i,
  input  wire logic [NUM_CHAN*SMP_W-1:0]   smp_mag_i,
  output logic                             adc_pwr_o,
  output logic                             ref_buf_en_o,
  output logic                             conv_start_o,
  output logic      [NUM_CHAN-1:0]         gain_hi_o,
  output logic                             frame_o,
  // interrupt
  output logic                             irq_o
);

  astc_wb_req_s req;
  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

  logic [2:0]   config_reg;
  logic [15:0]  period_reg;
  logic [15:0]  acq_reg;
  logic [15:0]  thresh_reg;
  logic [1:0]   status_reg;
  logic [1:0]   mask_reg;
  logic [15:0]  rate_cnt_reg;
  logic [15:0]  acq_cnt_reg;
  logic [2:0]   smp_idx_reg;
  astc_state_e  state_reg;
  logic         wr_en;
  logic         sample_tick;
  logic         smp_ev;
  logic         frame_ev;
  logic [1:0]   w1c;

  // a write lands on the edge at which the master samples ack, not one edge before it
  assign wr_en = req.cyc && req.stb && req.we && ack_o && req.sel[0];

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= CONFIG_RST;
      period_reg <= PERIOD_RST;
      acq_reg    <= ACQ_RST;
      thresh_reg <= THRESH_RST;
      mask_reg   <= MASK_RST;
    end else if (wr_en) begin
      case (req.adr)
        ADDR_CONFIG: config_reg <= req.dat[2:0];
        ADDR_PERIOD: if (req.sel[1]) period_reg <= req.dat[15:0];
        ADDR_ACQ:    if (req.sel[1]) acq_reg <= req.dat[15:0];
        ADDR_THRESH: if (req.sel[1]) thresh_reg <= req.dat[15:0];
        ADDR_MASK:   mask_reg <= req.dat[1:0];
        default:     ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read path and acknowledge, one wait state
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req.cyc && req.stb && !ack_o;
      case (req.adr)
        ADDR_CONFIG: dat_o <= {29'h0, config_reg};
        ADDR_PERIOD: dat_o <= {16'h0, period_reg};
        ADDR_ACQ:    dat_o <= {16'h0, acq_reg};
        ADDR_STATUS: dat_o <= {30'h0, status_reg};
        ADDR_MASK:   dat_o <= {30'h0, mask_reg};
        ADDR_CTRL:   dat_o <= {27'h0, smp_idx_reg, state_reg};
        ADDR_THRESH: dat_o <= {16'h0, thresh_reg};
        default:     dat_o <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sample rate divider
  // ------------------------------------------------------------------
  assign sample_tick = !config_reg[CFG_ADC_OFF] && (rate_cnt_reg == period_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i || config_reg[CFG_ADC_OFF]) begin
      rate_cnt_reg <= 16'h0;
    end else if (sample_tick) begin
      rate_cnt_reg <= 16'h0;
    end else begin
      rate_cnt_reg <= rate_cnt_reg + 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // power-on, settle, convert sequence
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || config_reg[CFG_ADC_OFF]) begin
      state_reg    <= ST_IDLE;
      acq_cnt_reg  <= 16'h0;
      adc_pwr_o    <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (state_reg)
        ST_IDLE: if (sample_tick) begin
          state_reg   <= ST_SETTLE;
          acq_cnt_reg <= 16'h0;
          adc_pwr_o   <= 1'b1;
        end
        ST_SETTLE: if (acq_cnt_reg == acq_reg) begin
          state_reg    <= ST_CONV;
          conv_start_o <= 1'b1;
        end else begin
          acq_cnt_reg <= acq_cnt_reg + 16'h1;
        end
        // a tick during conversion is dropped; period must exceed settle plus convert
        ST_CONV: if (conv_done_i) begin
          state_reg <= ST_IDLE;
          adc_pwr_o <= 1'b0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // frame grouping
  // ------------------------------------------------------------------
  assign smp_ev   = (state_reg == ST_CONV) && conv_done_i && !config_reg[CFG_ADC_OFF];
  assign frame_ev = smp_ev && (smp_idx_reg == FRAME_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_idx_reg <= 3'h0;
      frame_o     <= 1'b0;
    end else begin
      frame_o <= frame_ev;
      if (smp_ev) begin
        smp_idx_reg <= smp_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_buf_en_o <= 1'b0;
    end else begin
      ref_buf_en_o <= !config_reg[CFG_ADC_OFF] && !config_reg[CFG_REF_OFF];
    end
  end

  // ------------------------------------------------------------------
  // interrupt status, set wins over write-one-clear
  // ------------------------------------------------------------------
  assign w1c = (wr_en && req.adr == ADDR_STATUS) ? req.dat[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= 2'h0;
      irq_o      <= 1'b0;
    end else begin
      status_reg[ST_SAMPLE] <= smp_ev || (status_reg[ST_SAMPLE] && !w1c[ST_SAMPLE]);
      status_reg[ST_FRAME]  <= frame_ev || (status_reg[ST_FRAME] && !w1c[ST_FRAME]);
      irq_o <= !config_reg[CFG_IRQ_OFF] && |(status_reg & mask_reg);
    end
  end

  astc_gain_sel u_gain (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .smp_valid_i (smp_ev),
    .smp_mag_i   (smp_mag_i),
    .thresh_i    (thresh_reg),
    .gain_hi_o   (gain_hi_o)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_tick && !config_reg[CFG_ADC_OFF] && $stable(period_reg) && (period_reg != 16'h0) |=> !sample_tick)
    else $error("sample tick repeated too soon");
  AST_TICK_ROLL: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_tick |=> (rate_cnt_reg == 16'h0) || config_reg[CFG_ADC_OFF])
    else $error("rate counter not cleared on tick");
  AST_SETTLE: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start_o |-> $past(state_reg) == ST_SETTLE && $past(acq_cnt_reg) == $past(acq_reg))
    else $error("conversion started before settling");
  AST_PWR_START: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start_o |-> adc_pwr_o)
    else $error("conversion without power");
  AST_ADC_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    config_reg[CFG_ADC_OFF] |=> !adc_pwr_o && !conv_start_o)
    else $error("converter active while disabled");
  AST_REF_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    config_reg[CFG_REF_OFF] && $past(config_reg[CFG_REF_OFF]) |-> !ref_buf_en_o)
    else $error("reference buffer on while disabled");
  AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(config_reg[CFG_IRQ_OFF]) |-> !irq_o)
    else $error("interrupt raised while disabled");
  AST_GAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    smp_ev && smp_mag_i[SMP_W-1:0] < thresh_reg |=> gain_hi_o[0])
    else $error("gain not engaged for small input");
  AST_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_o |-> $past(smp_idx_reg) == FRAME_LAST && smp_idx_reg == 3'h0)
    else $error("frame not on eighth sample");

endmodule

/* File: hw/astc_pkg.sv */
// Purpose: shared constants and types for the converter sample timing block
// Assumes: one 100 MHz clock, classic Wishbone register access
// Notes:   register byte offsets are word aligned
package astc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD   = 8'h04;
  localparam logic [7:0] ADDR_ACQ      = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_MASK     = 8'h10;
  localparam logic [7:0] ADDR_CTRL     = 8'h14;
  localparam logic [7:0] ADDR_THRESH   = 8'h18;

  // config bit positions
  localparam int CFG_ADC_OFF   = 0;
  localparam int CFG_REF_OFF   = 1;
  localparam int CFG_IRQ_OFF   = 2;

  // status bit positions
  localparam int ST_SAMPLE     = 0;
  localparam int ST_FRAME      = 1;

  // reset values
  localparam logic [2:0]  CONFIG_RST   = 3'h0;
  localparam logic [15:0] PERIOD_RST   = 16'h013f;
  localparam logic [15:0] ACQ_RST      = 16'h002f;
  localparam logic [15:0] THRESH_RST   = 16'h0200;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  // last sample index of an eight-sample frame, channel count and sample width
  localparam logic [2:0]  FRAME_LAST   = 3'h7;
  localparam int          NUM_CHAN     = 4;
  localparam int          SMP_W        = 16;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV   = 2'b11
  } astc_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } astc_wb_req_s;

endpackage

/* File: hw/astc_gain_sel.sv */
// Purpose: per channel automatic gain-of-32 switching
// Assumes: sample magnitudes arrive with a one-cycle valid
// Notes:   gain engages below threshold, released at or above it
module astc_gain_sel
  import astc_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // samples
  input  wire logic                         smp_valid_i,
  input  wire logic [NUM_CHAN*SMP_W-1:0]    smp_mag_i,
  input  wire logic [15:0]                  thresh_i,
  // gain selects
  output logic      [NUM_CHAN-1:0]          gain_hi_o
);

  // ------------------------------------------------------------------
  // one decision per channel
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_ch
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        gain_hi_o[g] <= 1'b0;
      end else if (smp_valid_i) begin
        // a saturated high-gain reading also reads large, so it falls back
        gain_hi_o[g] <= (smp_mag_i[g*SMP_W +: SMP_W] < thresh_i);
      end
    end
  end

endmodule

/* File: tb/astc_adc_model.sv */
// Purpose: converter model answering start pulses with done and magnitudes
// Assumes: one clock, done pulse DLY cycles after a start pulse
// Notes:   magnitude lines toggle outside done so stale data is not trusted
module astc_adc_model
  import astc_pkg::*;
#(
  parameter int DLY = 20
)(
  // clock
  input  wire logic                      clk_i,
  // control
  input  wire logic                      conv_start_i,
  input  wire logic                      alt_i,
  // results
  output logic                           conv_done_o,
  output logic      [NUM_CHAN*SMP_W-1:0] smp_mag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  initial begin
    conv_done_o = 1'b0;
    smp_mag_o   = '0;
  end
  // plain always: the initial block also gives these outputs their start value
  always @(posedge clk_i) begin
    conv_done_o <= 1'b0;
    smp_mag_o   <= ~smp_mag_o;
    if (conv_start_i) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      conv_done_o <= 1'b1;
      smp_mag_o   <= alt_i ? 64'h0000_0200_0010_0300 : 64'h0300_01ff_0200_0100;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: register, timing, frame, gain and interrupt tests of the timing block
// Assumes: wishbone ack within 50 cycles, converter done after 20 cycles
// Notes:   period shortened by software, as other clock rates would need
module testbench
  import astc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, alt = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, conv_done_i, adc_pwr_o, ref_buf_en_o, conv_start_o, frame_o, irq_o;
  logic [NUM_CHAN*SMP_W-1:0] smp_mag_i;
  logic [NUM_CHAN-1:0] gain_hi_o;
  int num_errors = 0, num_checks = 0, cyc = 0, t1, t2;
  astc_top u_astc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .conv_done_i(conv_done_i), .smp_mag_i(smp_mag_i), .adc_pwr_o(adc_pwr_o),
    .ref_buf_en_o(ref_buf_en_o), .conv_start_o(conv_start_o), .gain_hi_o(gain_hi_o),
    .frame_o(frame_o), .irq_o(irq_o));
  astc_adc_model u_astc_adc_model (.clk_i(clk_i), .conv_start_i(conv_start_o), .alt_i(alt),
    .conv_done_o(conv_done_i), .smp_mag_o(smp_mag_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
    repeat (50) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    q = dat_o;
    if (ack_o !== 1'b1) chk("ack", 1, 0);
    cyc_i <= 1'b0; stb_i <= 1'b0;
  endtask
  // k: 0 start pulse, 1 power rise, 2 frame pulse
  task automatic ev(input int k, output int t);
    logic p;
    p = adc_pwr_o;
    t = -1;
    repeat (3000) begin
      @(posedge clk_i);
      if ((k == 0 && conv_start_o === 1'b1) || (k == 1 && adc_pwr_o === 1'b1 && p !== 1'b1) ||
          (k == 2 && frame_o === 1'b1)) begin
        t = cyc;
        break;
      end
      p = adc_pwr_o;
    end
    if (t < 0) chk("event", k, 32'hffff);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADDR_PERIOD, 0); chk("period rst", 32'h13f, q);
    wb(0, ADDR_ACQ, 0); chk("acq rst", 32'h2f, q);
    wb(0, ADDR_CONFIG, 0); chk("config rst", 32'h0, q);
    wb(0, ADDR_THRESH, 0); chk("thresh rst", 32'h200, q);
    chk("ref on", 1, ref_buf_en_o);
    wb(0, 8'h1c, 0); chk("unmapped", 32'h0, q);
    $display("test registers done");
    ev(0, t1); ev(0, t2); chk("period 320", 320, t2 - t1);
    ev(1, t1); ev(0, t2); chk("settle 48", 48, t2 - t1);
    wb(1, ADDR_PERIOD, 32'd99);
    wb(1, ADDR_ACQ, 32'd9);
    ev(0, t1); ev(0, t1); ev(0, t2); chk("period 100", 100, t2 - t1);
    ev(1, t1); ev(0, t2); chk("settle 10", 10, t2 - t1);
    ev(2, t1); ev(2, t2); chk("frame", 800, t2 - t1);
    $display("test timing done");
    ev(0, t1); chk("gain a", 4'b0101, gain_hi_o);
    alt <= 1'b1;
    ev(0, t1); ev(0, t1); chk("gain b", 4'b1010, gain_hi_o);
    $display("test gain done");
    ev(0, t1); repeat (40) @(posedge clk_i);
    chk("irq masked", 0, irq_o);
    wb(0, ADDR_STATUS, 0); chk("status set", 32'h3, q);
    wb(1, ADDR_MASK, 32'h1); repeat (2) @(posedge clk_i);
    chk("irq on", 1, irq_o);
    wb(0, ADDR_MASK, 0); chk("mask", 32'h1, q);
    wb(1, ADDR_CONFIG, 32'h4); repeat (2) @(posedge clk_i);
    chk("irq off", 0, irq_o);
    wb(1, ADDR_CONFIG, 32'h3); repeat (200) @(posedge clk_i);
    wb(1, ADDR_STATUS, 32'h3); repeat (400) @(posedge clk_i);
    chk("adc off pwr", 0, adc_pwr_o);
    chk("ref off", 0, ref_buf_en_o);
    wb(0, ADDR_STATUS, 0); chk("no samples", 0, q);
    chk("irq clear", 0, irq_o);
    $display("test config done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
endmodule
